/* hdl/usx_defs.svh */
`ifndef USX_DEFS_SVH
`define USX_DEFS_SVH

// register indices; byte address is four times the index
`define USX_IDX_IRQ_FLAGS 8'h0c
`define USX_IDX_RX_CTRL 8'h18
`define USX_IDX_TX_BUF 8'h19
`define USX_IDX_IRQ_EN 8'h8c
`define USX_IDX_TX_CTRL 8'h98
`define USX_IDX_BAUD_DIV 8'h99

// field positions
`define USX_BIT_TXBE_FLAG 4
`define USX_BIT_TX_IRQ_EN 4
`define USX_BIT_SERIAL_PORT_ENABLE 7
`define USX_BIT_SINGLE_RECEIVE_ENABLE 5
`define USX_BIT_CONTINUOUS_RECEIVE_ENABLE 4

// reset values
`define USX_RST_IRQ_FLAGS 8'h00
`define USX_RST_IRQ_EN 8'h00
`define USX_RST_TX_CTRL 8'h02
`define USX_RST_RX_CTRL 8'h00
`define USX_RST_TX_BUF 8'h00
`define USX_RST_BAUD_DIV 8'h00

// generator ticks per bit, minus one
`define USX_PRE_ASYNC_LO 6'h3f
`define USX_PRE_ASYNC_HI 6'h0f
`define USX_PRE_SYNC 6'h03

// frame lengths in bits
`define USX_LEN_ASYNC8 4'ha
`define USX_LEN_ASYNC9 4'hb
`define USX_LEN_SYNC8 4'h8
`define USX_LEN_SYNC9 4'h9

`endif

/* hdl/usx_pkg.sv */
`default_nettype none

package usx_pkg;

	typedef enum logic [1:0] {
		USX_IDLE,
		USX_ARMED,
		USX_SHIFT
	} usx_state_e;

	typedef struct packed {
		logic clock_source_select;
		logic nine_bit_transmit;
		logic transmit_enable;
		logic sync_mode_select;
		logic unused3;
		logic high_speed_select;
		logic shift_register_empty;
		logic ninth_transmit_bit;
	} usx_tx_ctrl_s;

	typedef struct packed {
		logic serial_port_enable;
		logic unused6;
		logic single_receive_enable;
		logic continuous_receive_enable;
		logic [3:0] unused0;
	} usx_rx_ctrl_s;

	typedef struct packed {
		logic dt_o;
		logic dt_oe_b;
		logic ck_o;
		logic ck_oe_b;
	} usx_pins_s;

endpackage

`default_nettype wire

/* hdl/usx_tx.sv */
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "usx_defs.svh"

module usx_tx
	import usx_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic rx_word_done_i,
	output logic rx_enable_o,
	output logic tx_irq_req_o,
	output logic dt_o,
	output logic dt_oe_b_o,
	input wire logic dt_i,
	output logic ck_o,
	output logic ck_oe_b_o,
	input wire logic ck_i
);

	// bus data phase
	logic dp_wr;
	logic dp_rd;
	logic rd_done;
	logic [7:0] dp_idx;
	logic take_addr;
	logic wr_en;

	// registers
	usx_tx_ctrl_s tx_ctrl;
	usx_rx_ctrl_s rx_ctrl;
	logic [7:0] irq_en;
	logic [7:0] baud_div;
	logic [7:0] buf_data;
	logic buf_full;
	logic txbe_flag;
	logic transmit_enable_q;

	// generator and shifter
	logic [7:0] brg_cnt;
	logic [5:0] phase;
	logic [5:0] phase_last;
	logic brg_run;
	logic brg_clr;
	logic tick;
	logic bit_ev;
	usx_state_e state;
	logic [10:0] frame;
	logic [3:0] cnt;
	logic txon;
	logic hold;
	logic mode_ok;
	logic buf_wr;
	logic load_ok;
	logic take;
	logic transmit_enable_rise;
	usx_pins_s next_pins;
	logic [7:0] rd_mux;

	// writes take no wait state; a read stalls for one cycle
	assign take_addr = hsel_i & htrans_i[1] & hready_i;
	assign wr_en = dp_wr & ce_i;
	assign hreadyout_o = ~(dp_rd & ~rd_done);
	assign hresp_o = 1'b0;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dp_wr <= 1'b0;
			dp_rd <= 1'b0;
			rd_done <= 1'b0;
			dp_idx <= 8'h00;
		end else if (ce_i) begin
			if (take_addr) begin
				dp_wr <= hwrite_i;
				dp_rd <= ~hwrite_i;
				rd_done <= 1'b0;
				dp_idx <= 8'(haddr_i[ADDR_W-1:2]);
			end else if (hreadyout_o) begin
				dp_wr <= 1'b0;
				dp_rd <= 1'b0;
			end else begin
				rd_done <= 1'b1;
			end
		end
	end

	always_comb begin
		case (dp_idx)
			`USX_IDX_IRQ_FLAGS: rd_mux = 8'(txbe_flag) << `USX_BIT_TXBE_FLAG;
			`USX_IDX_RX_CTRL: rd_mux = rx_ctrl;
			`USX_IDX_TX_BUF: rd_mux = buf_data;
			`USX_IDX_IRQ_EN: rd_mux = irq_en;
			`USX_IDX_TX_CTRL: rd_mux = tx_ctrl;
			`USX_IDX_BAUD_DIV: rd_mux = baud_div;
			default: rd_mux = 8'h00;
		endcase
	end

	// one wait state so a read sees a write just before it
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (ce_i && dp_rd && !rd_done) begin
			hrdata_o <= {24'h00_0000, rd_mux};
		end
	end

	assign buf_wr = wr_en && dp_idx == `USX_IDX_TX_BUF;
	assign brg_clr = wr_en && dp_idx == `USX_IDX_BAUD_DIV;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_ctrl <= `USX_RST_TX_CTRL;
		end else if (ce_i) begin
			if (wr_en && dp_idx == `USX_IDX_TX_CTRL) begin
				tx_ctrl <= hwdata_i[7:0];
			end
			tx_ctrl.unused3 <= 1'b0;
			tx_ctrl.shift_register_empty <= next_state_idle();
		end
	end

	function automatic logic next_state_idle();
		return state == USX_IDLE && !take;
	endfunction

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_ctrl <= `USX_RST_RX_CTRL;
		end else if (ce_i) begin
			if (wr_en && dp_idx == `USX_IDX_RX_CTRL) begin
				rx_ctrl <= hwdata_i[7:0];
				rx_ctrl.unused6 <= 1'b0;
				rx_ctrl.unused0 <= 4'h0;
			end else if (rx_word_done_i) begin
				rx_ctrl.single_receive_enable <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_en <= `USX_RST_IRQ_EN;
			baud_div <= `USX_RST_BAUD_DIV;
		end else if (ce_i) begin
			if (wr_en && dp_idx == `USX_IDX_IRQ_EN) begin
				irq_en <= hwdata_i[7:0];
			end
			if (brg_clr) begin
				baud_div <= hwdata_i[7:0];
			end
		end
	end

	// transmit buffer and its empty flag
	assign transmit_enable_rise = tx_ctrl.transmit_enable & ~transmit_enable_q;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			buf_data <= `USX_RST_TX_BUF;
			buf_full <= 1'b0;
			txbe_flag <= 1'b0;
			transmit_enable_q <= 1'b0;
		end else if (ce_i) begin
			transmit_enable_q <= tx_ctrl.transmit_enable;
			if (buf_wr) begin
				buf_data <= hwdata_i[7:0];
				buf_full <= 1'b1;
			end else if (take) begin
				buf_full <= 1'b0;
			end
			// a set in the same cycle as a buffer write wins
			if (take || (transmit_enable_rise && !buf_full)) begin
				txbe_flag <= 1'b1;
			end else if (buf_wr) begin
				txbe_flag <= 1'b0;
			end
		end
	end

	assign tx_irq_req_o = txbe_flag & irq_en[`USX_BIT_TX_IRQ_EN];

	// baud generator
	// a tick every divisor+1 clocks; one bit is phase_last+1 ticks
	assign brg_run = tx_ctrl.transmit_enable | rx_ctrl.continuous_receive_enable
		| rx_ctrl.single_receive_enable;
	assign tick = brg_cnt >= baud_div;

	always_comb begin
		if (tx_ctrl.sync_mode_select) begin
			phase_last = `USX_PRE_SYNC;
		end else if (tx_ctrl.high_speed_select) begin
			phase_last = `USX_PRE_ASYNC_HI;
		end else begin
			phase_last = `USX_PRE_ASYNC_LO;
		end
	end

	assign bit_ev = tick && phase >= phase_last;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			brg_cnt <= 8'h00;
			phase <= 6'h00;
		end else if (ce_i) begin
			if (!brg_run || brg_clr) begin
				brg_cnt <= 8'h00;
				phase <= 6'h00;
			end else if (tick) begin
				brg_cnt <= 8'h00;
				phase <= bit_ev ? 6'h00 : phase + 6'h01;
			end else begin
				brg_cnt <= brg_cnt + 8'h01;
			end
		end
	end

	// shifter control
	// receive enable in sync mode only freezes the shifter;
	// clearing transmit enable or serial port enable is what resets it
	assign txon = tx_ctrl.transmit_enable & rx_ctrl.serial_port_enable;
	assign rx_enable_o = rx_ctrl.continuous_receive_enable | rx_ctrl.single_receive_enable;
	assign hold = tx_ctrl.sync_mode_select & rx_enable_o;
	assign mode_ok = ~tx_ctrl.sync_mode_select | tx_ctrl.clock_source_select;
	assign load_ok = buf_full & ~buf_wr;
	assign take = txon && !hold && mode_ok && load_ok
		&& (state == USX_IDLE || (state == USX_SHIFT && bit_ev && cnt == 4'h1));

	function automatic logic [10:0] build_frame(input logic [7:0] data, input logic ninth,
		input logic nine, input logic sync);
		if (sync) begin
			return {2'b11, ninth, data};
		end
		return {1'b1, nine ? ninth : 1'b1, data, 1'b0};
	endfunction

	function automatic logic [3:0] frame_len(input logic nine, input logic sync);
		if (sync) begin
			return nine ? `USX_LEN_SYNC9 : `USX_LEN_SYNC8;
		end
		return nine ? `USX_LEN_ASYNC9 : `USX_LEN_ASYNC8;
	endfunction

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= USX_IDLE;
			frame <= 11'h7ff;
			cnt <= 4'h0;
		end else if (ce_i) begin
			if (!txon) begin
				state <= USX_IDLE;
				cnt <= 4'h0;
			end else if (take) begin
				// ninth bit sampled here
				frame <= build_frame(buf_data, tx_ctrl.ninth_transmit_bit,
					tx_ctrl.nine_bit_transmit, tx_ctrl.sync_mode_select);
				cnt <= frame_len(tx_ctrl.nine_bit_transmit, tx_ctrl.sync_mode_select);
				state <= state == USX_SHIFT ? USX_SHIFT : USX_ARMED;
			end else if (!hold && mode_ok && bit_ev) begin
				case (state)
					USX_ARMED: state <= USX_SHIFT;
					USX_SHIFT: begin
						if (cnt == 4'h1) begin
							state <= USX_IDLE;
						end else begin
							frame <= {1'b1, frame[10:1]};
							cnt <= cnt - 4'h1;
						end
					end
					default: state <= state;
				endcase
			end
		end
	end

	// pins; output enables are active low
	// registered, so pins trail the shifter state by one clock
	always_comb begin
		next_pins.dt_o = state == USX_SHIFT ? frame[0] : 1'b1;
		next_pins.dt_oe_b = ~(txon & ~hold);
		// bit changes at wrap, clock rises there and falls mid-bit
		next_pins.ck_o = state == USX_SHIFT && phase < 6'h02;
		next_pins.ck_oe_b = ~(rx_ctrl.serial_port_enable & tx_ctrl.sync_mode_select
			& tx_ctrl.clock_source_select & (tx_ctrl.transmit_enable | rx_enable_o));
		if (!tx_ctrl.sync_mode_select) begin
			next_pins.ck_o = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dt_o <= 1'b1;
			dt_oe_b_o <= 1'b1;
			ck_o <= 1'b0;
			ck_oe_b_o <= 1'b1;
		end else if (ce_i) begin
			dt_o <= next_pins.dt_o;
			dt_oe_b_o <= next_pins.dt_oe_b;
			ck_o <= next_pins.ck_o;
			ck_oe_b_o <= next_pins.ck_oe_b;
		end
	end

endmodule // usx_tx

`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [9:0] FL = 10'h030, RX = 10'h060, TB = 10'h064, IE = 10'h230, TC = 10'h260, DV = 10'h264;
	logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, rxd = 0;
	logic [1:0] htrans = 0;
	logic [9:0] haddr = 0;
	logic [31:0] hwdata = 0, rd;
	logic [7:0] bitl = 8'h10;
	logic [3:0] nb = 4'h8;
	wire logic hro, hresp, rxen, irq, dto, dt_oe_b, cko, ck_oe_b, dtw, ckw;
	wire logic [31:0] hrdata;
	wire logic [9:0] aw;
	wire logic [8:0] sw;
	wire logic [7:0] ac;
	int bad_count = 0, num_checks = 0;
	always #5 clk = ~clk;
	usx_tx dut(.ref_clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hro),
		.hreadyout_o(hro), .hresp_o(hresp), .hrdata_o(hrdata), .rx_word_done_i(rxd), .rx_enable_o(rxen),
		.tx_irq_req_o(irq), .dt_o(dto), .dt_oe_b_o(dt_oe_b), .dt_i(dtw), .ck_o(cko), .ck_oe_b_o(ck_oe_b),
		.ck_i(ckw));
	usx_line_rx peer(.clk_i(clk), .dt_i(dto), .dt_oe_b_i(dt_oe_b), .ck_i(cko), .ck_oe_b_i(ck_oe_b),
		.bit_i(bitl), .nbits_i(nb), .dt_w_o(dtw), .ck_w_o(ckw), .word_o(aw), .cnt_o(ac), .sync_o(sw));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic step(inout int n);
		@(negedge clk);
		n++;
		if (n > 9999) begin
			bad_count++;
			wrap_up();
		end
	endtask
	// hready judged at the rising edge, read data kept from that cycle
	task automatic wt;
		int n = 0;
		logic r;
		do begin
			step(n);
			r = hro;
			rd = hrdata;
			@(posedge clk);
		end while (r !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wt();
		hsel <= 0;
		htrans <= 0;
		hwdata <= {24'h0, d};
		wt();
	endtask
	task automatic t_reset;
		logic [9:0] a [7] = '{FL, RX, TB, IE, TC, DV, 10'h3fc};
		logic [7:0] e [7] = '{0, 0, 0, 0, 8'h02, 0, 0};
		for (int i = 0; i < 7; i++) begin
			bus(0, a[i], 0);
			chk(rd, e[i]);
		end
		bus(1, TC, 8'h00);
		bus(0, TC, 0);
		chk(rd, 32'h02);
		bus(1, DV, 8'hff);
		bus(0, DV, 0);
		chk(rd, 32'hff);
		$display("reset test end");
	endtask
	task automatic t_async(input logic [7:0] dv, input logic hs, nn, input logic [7:0] d);
		int n = 0;
		logic [7:0] c0;
		bitl = 8'((hs ? 16 : 64) * (dv + 1));
		nb = nn ? 4'h9 : 4'h8;
		bus(1, DV, dv);
		bus(1, TC, {5'h0, hs, 2'h0});
		bus(1, RX, 8'h80);
		bus(1, IE, 8'h10);
		bus(1, TC, {1'b0, nn, 3'h4, hs, 2'h0});
		bus(0, FL, 0);
		chk(rd, 32'h10);
		chk(irq, 1);
		bus(1, TC, {1'b0, nn, 3'h4, hs, 1'b0, nn});
		c0 = ac;
		bus(1, TB, d);
		bus(1, TB, ~d);
		bus(0, FL, 0);
		chk(rd, 0);
		bus(0, TC, 0);
		chk(rd[1], 0);
		while (ac != c0 + 8'h2) step(n);
		chk(aw, {nn, 1'b1, ~d});
		bus(0, FL, 0);
		chk(rd, 32'h10);
		bus(1, TC, 8'h00);
		$display("async test end");
	endtask
	task automatic t_sync;
		int n = 0;
		bus(1, DV, 8'h02);
		bus(1, TC, 8'h94);
		bus(1, RX, 8'h80);
		bus(1, TC, 8'hb4);
		bus(1, TB, 8'h96);
		// generator starts at the enable: bit edge 12 clocks on, pin one later
		while (cko !== 1'b1) step(n);
		chk(n, 11);
		n = 0;
		while (cko !== 1'b0) step(n);
		while (cko !== 1'b1) step(n);
		chk(n, 12);
		repeat (96) @(negedge clk);
		chk(sw[8:1], 8'h96);
		chk(cko, 0);
		$display("sync test end");
	endtask
	task automatic t_abort;
		int n = 0;
		bus(1, DV, 8'h02);
		bus(1, TB, 8'h5a);
		// divisor write restarts the generator, same timing as an enable
		while (cko !== 1'b1) step(n);
		chk(n, 11);
		repeat (30) @(negedge clk);
		bus(1, RX, 8'ha0);
		repeat (4) @(negedge clk);
		chk({rxen, dt_oe_b, ck_oe_b}, 3'b110);
		@(posedge clk) rxd <= 1;
		@(posedge clk) rxd <= 0;
		repeat (4) @(negedge clk);
		chk({rxen, dt_oe_b}, 2'b00);
		bus(1, TC, 8'h90);
		repeat (4) @(negedge clk);
		chk({dt_oe_b, ck_oe_b}, 2'b11);
		$display("abort test end");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		t_reset();
		t_async(8'h00, 1'b1, 1'b0, 8'ha5);
		t_async(8'h01, 1'b0, 1'b1, 8'h3c);
		t_sync();
		t_abort();
		wrap_up();
	end
endmodule // testbench
`default_nettype wire

/* sim/usx_line_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module usx_line_rx (
	input wire logic clk_i,
	input wire logic dt_i,
	input wire logic dt_oe_b_i,
	input wire logic ck_i,
	input wire logic ck_oe_b_i,
	input wire logic [7:0] bit_i,
	input wire logic [3:0] nbits_i,
	output logic dt_w_o,
	output logic ck_w_o,
	output logic [9:0] word_o,
	output logic [7:0] cnt_o,
	output logic [8:0] sync_o
);
	logic dl = 1'b0;
	logic cl = 1'b0;
	// released lines show the inverse of the last driven level
	always @(posedge clk_i) begin
		if (!dt_oe_b_i) dl <= dt_i;
		if (!ck_oe_b_i) cl <= ck_i;
	end
	assign dt_w_o = dt_oe_b_i ? ~dl : dt_i;
	assign ck_w_o = ck_oe_b_i ? ~cl : ck_i;
	initial begin
		cnt_o = 0;
		word_o = 0;
		sync_o = 0;
	end
	// async: mid-bit sampling of data, ninth and stop
	always begin
		@(negedge dt_w_o);
		if (ck_oe_b_i && !dt_oe_b_i) begin
			repeat (bit_i / 2) @(posedge clk_i);
			word_o = 0;
			for (int i = 0; i <= nbits_i; i++) begin
				repeat (bit_i) @(posedge clk_i);
				word_o[i] = dt_w_o;
			end
			cnt_o = cnt_o + 8'h1;
		end
	end
	always @(negedge ck_w_o) if (!ck_oe_b_i) sync_o <= {dt_w_o, sync_o[8:1]};
endmodule // usx_line_rx
`default_nettype wire

/* sim/usx_tx_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module usx_tx_sva (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [31:0] hrdata_o,
	input wire logic rx_enable_o,
	input wire logic dt_o,
	input wire logic dt_oe_b_o,
	input wire logic ck_o,
	input wire logic ck_oe_b_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic take = ce_i && hsel_i && htrans_i[1] && hready_i;
	AST_READ_WAIT: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait wrong");
	AST_WRITE_NOWAIT: assert property (take && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	AST_LOW_CAUSE: assert property ($fell(hreadyout_o) |-> $past(take) && !$past(hwrite_i))
		else $error("stray wait");
	AST_OKAY: assert property (!hresp_o)
		else $error("error response");
	AST_BYTE_DATA: assert property (hrdata_o[31:8] == 24'h0)
		else $error("upper bits set");
	AST_HALF_DUPLEX: assert property ($rose(rx_enable_o) && !ck_oe_b_o |-> ##[1:3] dt_oe_b_o)
		else $error("data kept");
	AST_DT_ON_RISE: assert property (!ck_oe_b_o && !dt_oe_b_o && !$past(dt_oe_b_o) && ck_o && $changed(dt_o)
		|-> $rose(ck_o))
		else $error("data moved");
	AST_DT_HOLD_FALL: assert property ($fell(ck_o) && !ck_oe_b_o && !dt_oe_b_o |=> $stable(dt_o) || dt_oe_b_o)
		else $error("data unstable");
endmodule // usx_tx_sva
bind usx_tx usx_tx_sva sva(.ref_clk_i, .rst_b_i, .ce_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
	.hreadyout_o, .hresp_o, .hrdata_o, .rx_enable_o, .dt_o, .dt_oe_b_o, .ck_o, .ck_oe_b_o);
`default_nettype wire
